// ===== core/disk_irq_pkg.sv
package disk_irq_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_ERROR     = 8'h08;
  localparam logic [7:0] OFS_INTERLOCK = 8'h0c;
  localparam logic [7:0] OFS_DRIVE     = 8'h10;

  // ==========================================================
  // control register fields
  localparam int CTL_IRQ_ENABLE  = 0;
  localparam int CTL_HDR_ENABLE  = 1;
  localparam int CTL_INTERLOCK   = 2;
  localparam int CTL_SOFT_RESET  = 3;
  localparam int CTL_TRACKING    = 4;
  localparam int CTL_REMOTE_EN   = 5;
  localparam int CTL_DUAL_CHAN   = 6;
  localparam int CTL_EXT_DMA     = 7;
  localparam int CTL_APPEND_CHK  = 8;
  localparam int CTL_WIDTH       = 9;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h100;

  // ==========================================================
  // status register fields
  localparam int STS_NEXT_CMD    = 0;
  localparam int STS_HEADER_DONE = 1;
  localparam int STS_ERROR_SEEN  = 2;
  localparam int STS_CORR_DONE   = 3;
  localparam int STS_WIDTH       = 4;

  // ==========================================================
  // error register fields
  localparam int ERR_DATA_CHECK  = 0;
  localparam int ERR_SECTOR_MISS = 1;
  localparam int ERR_OVERRUN     = 2;
  localparam int ERR_NO_SYNC     = 3;
  localparam int ERR_FIFO_LOSS   = 4;
  localparam int ERR_CORR_FAIL   = 5;
  localparam int ERR_LATE_ILOCK  = 6;
  localparam int ERR_PARTIAL_HDR = 7;
  localparam int ERR_WIDTH       = 8;

  // ==========================================================
  // drive command register
  localparam int DRV_CMD_ENABLE  = 0;

endpackage : disk_irq_pkg

// ===== core/disk_ctrl_interrupt_logic.sv
// What this block does
// - interrupt only while irq_enable set
// - operation done raises operation-complete interrupt
// - tracking read: interrupt at remote transfer end
// - non-tracking local-only read: interrupt at local end
// - non-tracking remote enabled: interrupt at remote end
// - multi-sector: interrupt only after last sector, except non-tracking remote end
// - write: interrupt on last postamble byte out
// - header-check: interrupt on first postamble byte in
// - local-only read: interrupt with last write strobe
// - dual/external DMA: interrupt with last read strobe
// - header interrupt each sector when enabled
// - header interrupt with next_command_flag set
// - header interrupt at first ID postamble byte
// - any error bit sets error_seen_flag, interrupts
// - correction end interrupts; failure only sets flag
// - status shows operation, header, error flags
// - error register holds eight error flags
// - status read forces interrupt inactive high
// - event during status read fires afterwards
// - soft or pin reset clears; drive enable no
// - append off writes data without check bytes
// - external check error treated as internal
// - late interlock sets error and terminates
`timescale 1ns/1ps
module disk_ctrl_interrupt_logic (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // sequencer events, one-cycle pulses on pclk except the op type, last_sector and corr_uncorrectable levels
  input  wire logic        op_is_read,
  input  wire logic        op_is_write,
  input  wire logic        op_is_hdr_check,
  input  wire logic        last_sector,
  input  wire logic        write_post_last_out,
  input  wire logic        check_post_first_in,
  input  wire logic        local_xfer_done,
  input  wire logic        remote_xfer_done,
  input  wire logic        last_wr_strobe,
  input  wire logic        last_rd_strobe,
  input  wire logic        id_post_first_byte,
  input  wire logic        sector_data_end,
  input  wire logic        corr_cycle_done,
  input  wire logic        corr_uncorrectable,
  input  wire logic        int_check_err,
  input  wire logic        ext_check_err,
  input  wire logic [7:0]  err_set,
  // data path control
  output logic             append_check,
  output logic             op_terminate,
  // interrupt pin
  output logic             irq_n
);

  // ==========================================================
  // bus decode
  logic acc;
  logic wr;
  logic rd_status;
  logic rd_error;
  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign rd_status = acc && !pwrite && paddr == disk_irq_pkg::OFS_STATUS;
  assign rd_error  = acc && !pwrite && paddr == disk_irq_pkg::OFS_ERROR;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, disk_irq_pkg::OFS_CONTROL) || hit(a, disk_irq_pkg::OFS_STATUS) || hit(a, disk_irq_pkg::OFS_ERROR)
             || hit(a, disk_irq_pkg::OFS_INTERLOCK) || hit(a, disk_irq_pkg::OFS_DRIVE);
  endfunction : mapped

  // ==========================================================
  // state
  logic [disk_irq_pkg::CTL_WIDTH-1:0] ctl_reg, ctl_next;
  logic [disk_irq_pkg::STS_WIDTH-1:0] sts_reg, sts_next;
  logic [disk_irq_pkg::ERR_WIDTH-1:0] err_reg, err_next;
  logic                               drv_reg, drv_next;
  logic                               ilock_reg, ilock_next;
  logic                               pend_reg, pend_next;
  logic                               irq_n_reg, irq_n_next;
  logic                               term_reg, term_next;
  logic [31:0]                        rdata_reg, rdata_next;
  logic                               ready_reg, ready_next;
  logic                               slverr_reg, slverr_next;

  // ==========================================================
  // event sources
  logic soft_rst;
  logic op_done;
  logic hdr_done;
  logic late_il;
  logic [7:0] err_new;
  logic err_event;
  logic any_event;
  logic local_only;
  logic unreported;

  assign soft_rst   = ctl_reg[disk_irq_pkg::CTL_SOFT_RESET];
  assign unreported = |(sts_reg & ~rdata_reg[disk_irq_pkg::STS_WIDTH-1:0]);
  assign local_only = !ctl_reg[disk_irq_pkg::CTL_DUAL_CHAN] && !ctl_reg[disk_irq_pkg::CTL_EXT_DMA];

  always_comb begin
    op_done = 1'b0;
    if (last_sector) begin
      if (op_is_write && write_post_last_out) begin
        op_done = 1'b1;
      end
      if (op_is_hdr_check && check_post_first_in) begin
        op_done = 1'b1;
      end
      if (op_is_read) begin
        if (ctl_reg[disk_irq_pkg::CTL_TRACKING]) begin
          op_done = remote_xfer_done;
        end else if (local_only) begin
          op_done = local_xfer_done && last_wr_strobe;
        end else begin
          op_done = last_rd_strobe;
        end
      end
    end
    if (!ctl_reg[disk_irq_pkg::CTL_TRACKING] && ctl_reg[disk_irq_pkg::CTL_REMOTE_EN] && remote_xfer_done) begin
      op_done = 1'b1;
    end
  end

  assign hdr_done  = id_post_first_byte && ctl_reg[disk_irq_pkg::CTL_HDR_ENABLE];
  assign late_il   = ctl_reg[disk_irq_pkg::CTL_INTERLOCK] && sector_data_end && !ilock_reg;

  always_comb begin
    err_new = err_set;
    if (int_check_err || ext_check_err) begin
      err_new[disk_irq_pkg::ERR_DATA_CHECK] = 1'b1;
    end
    if (corr_cycle_done && corr_uncorrectable) begin
      err_new[disk_irq_pkg::ERR_CORR_FAIL] = 1'b1;
    end
    if (late_il) begin
      err_new[disk_irq_pkg::ERR_LATE_ILOCK] = 1'b1;
    end
  end

  assign err_event = |err_new;
  assign any_event = op_done || hdr_done || err_event || corr_cycle_done;

  // ==========================================================
  // bus answer: one wait-free access phase
  always_comb begin
    ready_next  = 1'b0;
    slverr_next = 1'b0;
    rdata_next  = rdata_reg;
    if (psel && !penable) begin
      ready_next  = 1'b1;
      slverr_next = !mapped(paddr);
      rdata_next  = 32'h0000_0000;
      if (hit(paddr, disk_irq_pkg::OFS_CONTROL)) begin
        rdata_next = {23'h000000, ctl_reg};
      end
      if (hit(paddr, disk_irq_pkg::OFS_STATUS)) begin
        rdata_next = {28'h0000000, sts_reg};
      end
      if (hit(paddr, disk_irq_pkg::OFS_ERROR)) begin
        rdata_next = {24'h000000, err_reg};
      end
      if (hit(paddr, disk_irq_pkg::OFS_DRIVE)) begin
        rdata_next = {31'h00000000, drv_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg  <= 1'b0;
      slverr_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      ready_reg  <= ready_next;
      slverr_reg <= slverr_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ==========================================================
  // control register, soft reset bit clears itself
  always_comb begin
    ctl_next = ctl_reg;
    if (soft_rst) begin
      ctl_next[disk_irq_pkg::CTL_SOFT_RESET] = 1'b0;
    end
    if (wr && hit(paddr, disk_irq_pkg::OFS_CONTROL)) begin
      ctl_next = pwdata[disk_irq_pkg::CTL_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= disk_irq_pkg::CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ==========================================================
  // drive command enable, no effect on the pin
  always_comb begin
    drv_next = drv_reg;
    if (wr && hit(paddr, disk_irq_pkg::OFS_DRIVE)) begin
      drv_next = pwdata[disk_irq_pkg::DRV_CMD_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_reg <= 1'b0;
    end else begin
      drv_reg <= drv_next;
    end
  end

  // ==========================================================
  // status flags, a read clears only what it showed
  always_comb begin
    sts_next = sts_reg;
    if (rd_status) begin
      sts_next = sts_reg & ~rdata_reg[disk_irq_pkg::STS_WIDTH-1:0];
    end
    // hardware sets win over the read clear
    if (op_done || hdr_done) begin
      sts_next[disk_irq_pkg::STS_NEXT_CMD] = 1'b1;
    end
    if (hdr_done) begin
      sts_next[disk_irq_pkg::STS_HEADER_DONE] = 1'b1;
    end
    if (err_event) begin
      sts_next[disk_irq_pkg::STS_ERROR_SEEN] = 1'b1;
    end
    if (corr_cycle_done) begin
      sts_next[disk_irq_pkg::STS_CORR_DONE] = 1'b1;
    end
    if (soft_rst) begin
      sts_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_reg <= '0;
    end else begin
      sts_reg <= sts_next;
    end
  end

  // ==========================================================
  // error flags, a read clears only what it showed
  always_comb begin
    err_next = err_reg;
    if (rd_error) begin
      err_next = err_reg & ~rdata_reg[disk_irq_pkg::ERR_WIDTH-1:0];
    end
    // hardware sets win over the read clear
    err_next = err_next | err_new;
    if (soft_rst) begin
      err_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= '0;
    end else begin
      err_reg <= err_next;
    end
  end

  // ==========================================================
  // interlock armed flag, one sector at a time
  always_comb begin
    ilock_next = ilock_reg;
    if (sector_data_end) begin
      ilock_next = 1'b0;
    end
    if (wr && hit(paddr, disk_irq_pkg::OFS_INTERLOCK)) begin
      ilock_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilock_reg <= 1'b0;
    end else begin
      ilock_reg <= ilock_next;
    end
  end

  // ==========================================================
  // terminate pulse on late interlock
  always_comb begin
    term_next = late_il;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_reg <= 1'b0;
    end else begin
      term_reg <= term_next;
    end
  end

  // ==========================================================
  // pending latch, kept while a source is unreported
  always_comb begin
    pend_next = pend_reg;
    if (rd_status) begin
      pend_next = unreported;
    end
    if (any_event) begin
      pend_next = 1'b1;
    end
    if (soft_rst) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ==========================================================
  // interrupt pin, follows the enable bit one cycle late
  always_comb begin
    if (rd_status) begin
      irq_n_next = 1'b1;
    end else begin
      irq_n_next = !(pend_next && ctl_reg[disk_irq_pkg::CTL_IRQ_ENABLE]);
    end
    if (soft_rst) begin
      irq_n_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= irq_n_next;
    end
  end

  // ==========================================================
  // outputs
  assign irq_n        = irq_n_reg;
  assign op_terminate = term_reg;
  assign append_check = ctl_reg[disk_irq_pkg::CTL_APPEND_CHK];
  assign pready       = ready_reg;
  assign prdata       = rdata_reg;
  assign pslverr      = slverr_reg;

endmodule : disk_ctrl_interrupt_logic

// ===== dv/disk_irq_asserts.sv
`timescale 1ns/1ps
module disk_irq_asserts (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // events and pin
  input wire logic        id_post_first_byte,
  input wire logic        corr_cycle_done,
  input wire logic [7:0]  err_set,
  input wire logic        irq_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // enable bits as last written, access history
  logic [1:0] en_reg, en_next;
  logic       acc_reg, acc, quiet;
  assign acc   = psel && penable;
  assign quiet = en_reg[0] && !acc && !acc_reg;
  always_comb begin
    en_next = en_reg;
    if (acc && pwrite && paddr == 8'h00) begin
      en_next = pwdata[1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg  <= 2'h0;
      acc_reg <= 1'b0;
    end else begin
      en_reg  <= en_next;
      acc_reg <= acc;
    end
  end
  // ==========================================
  // assertions
  ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  unmapped_refused_a: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  irq_off_a: assert property (!en_reg[0] |=> irq_n)
    else $error("irq while disabled");
  sts_clr_a: assert property (acc && !pwrite && paddr == 8'h04 |=> irq_n)
    else $error("status read left irq active");
  err_irq_a: assert property (quiet && err_set != 8'h0 |=> !irq_n)
    else $error("error bit gave no irq");
  hdr_irq_a: assert property (quiet && en_reg[1] && id_post_first_byte |=> !irq_n)
    else $error("header event gave no irq");
  corr_irq_a: assert property (quiet && corr_cycle_done |=> !irq_n)
    else $error("correction end gave no irq");
  read_race_a: assert property (en_reg[0] && acc && !pwrite && paddr == 8'h04 && corr_cycle_done |=> irq_n ##1 !irq_n)
    else $error("event during status read lost");
  cover property (quiet && corr_cycle_done);
  cover property (acc && !pwrite && paddr == 8'h04 && !irq_n);
  cover property (pready && pslverr);
endmodule : disk_irq_asserts

bind disk_ctrl_interrupt_logic disk_irq_asserts disk_irq_asserts_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .id_post_first_byte, .corr_cycle_done, .err_set, .irq_n);

// ===== dv/host_model.sv
`timescale 1ns/1ps
module host_model (
  // apb master side
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
  // ==========================================
  // one apb transfer, held until pready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
  // ==========================================
  // interrupt service: status, then error only if flagged
  task service(output logic [31:0] s, output logic [31:0] er);
    logic x;
    xfer(1'b0, disk_irq_pkg::OFS_STATUS, 32'h0, s, x);
    er = 32'h0;
    if (s[disk_irq_pkg::STS_ERROR_SEEN]) xfer(1'b0, disk_irq_pkg::OFS_ERROR, 32'h0, er, x);
  endtask : service
endmodule : host_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================
  // signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        append_check, op_terminate, irq_n, sl;
  logic [4:0]  lv;
  logic [7:0]  paddr;
  logic [18:0] ev;
  logic [31:0] pwdata, prdata, rd, er;
  int          error_cnt, checked, cyc, n_term;

  disk_ctrl_interrupt_logic disk_ctrl_interrupt_logic_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .op_is_read(lv[4]), .op_is_write(lv[3]), .op_is_hdr_check(lv[2]), .last_sector(lv[1]),
    .corr_uncorrectable(lv[0]), .write_post_last_out(ev[18]), .check_post_first_in(ev[17]),
    .local_xfer_done(ev[16]), .remote_xfer_done(ev[15]), .last_wr_strobe(ev[14]),
    .last_rd_strobe(ev[13]), .id_post_first_byte(ev[12]), .sector_data_end(ev[11]),
    .corr_cycle_done(ev[10]), .int_check_err(ev[9]), .ext_check_err(ev[8]), .err_set(ev[7:0]),
    .append_check, .op_terminate, .irq_n);
  host_model host_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (op_terminate === 1'b1) n_term <= n_term + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end
  // ==========================================
  // checking and closing
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // ==========================================
  // one event under a control setting, then service
  task run(input logic [8:0] c, input logic [4:0] l, input logic [18:0] e,
           input logic ie, input logic [3:0] se, input logic [7:0] ee);
    host_model_i.xfer(1'b1, 8'h00, {23'h0, c}, rd, sl);
    lv <= l;
    @(posedge pclk) ev <= e;
    @(posedge pclk) ev <= 19'h0;
    #1 chk("irq_n", irq_n, ie);
    host_model_i.service(rd, er);
    chk("status", rd, {28'h0, se});
    chk("error", er, {24'h0, ee});
    lv <= 5'h0;
    #1 chk("irq_n", irq_n, 1'b1);
  endtask : run
  // ==========================================
  // scenarios
  task t_misc;
    #1 chk("irq_n", irq_n, 1'b1);
    host_model_i.xfer(1'b0, 8'h00, 32'h0, rd, sl);
    chk("control", rd, 32'h100);
    host_model_i.xfer(1'b0, 8'h14, 32'h0, rd, sl);
    chk("slverr", sl, 1'b1);
    host_model_i.xfer(1'b1, 8'h00, 32'h001, rd, sl);
    @(posedge pclk) #1 chk("append", append_check, 1'b0);
  endtask : t_misc
  task t_table;
    run(9'h101, 5'h0a, 19'h40000, 1'b0, 4'h1, 8'h0);
    run(9'h101, 5'h08, 19'h40000, 1'b1, 4'h0, 8'h0);
    run(9'h101, 5'h06, 19'h20000, 1'b0, 4'h1, 8'h0);
    run(9'h111, 5'h12, 19'h08000, 1'b0, 4'h1, 8'h0);
    run(9'h101, 5'h12, 19'h14000, 1'b0, 4'h1, 8'h0);
    run(9'h121, 5'h12, 19'h08000, 1'b0, 4'h1, 8'h0);
    run(9'h141, 5'h12, 19'h02000, 1'b0, 4'h1, 8'h0);
    run(9'h181, 5'h12, 19'h02000, 1'b0, 4'h1, 8'h0);
    run(9'h103, 5'h00, 19'h01000, 1'b0, 4'h3, 8'h0);
    run(9'h103, 5'h08, 19'h01000, 1'b0, 4'h3, 8'h0);
    run(9'h101, 5'h00, 19'h00400, 1'b0, 4'h8, 8'h0);
    run(9'h101, 5'h01, 19'h00400, 1'b0, 4'hc, 8'h20);
    run(9'h101, 5'h00, 19'h00200, 1'b0, 4'h4, 8'h01);
    run(9'h101, 5'h00, 19'h00100, 1'b0, 4'h4, 8'h01);
    run(9'h100, 5'h00, 19'h00001, 1'b1, 4'h4, 8'h01);
    for (int i = 0; i < 8; i++) run(9'h101, 5'h0, 19'h1 << i, 1'b0, 4'h4, 8'h1 << i);
  endtask : t_table
  task t_race;
    host_model_i.xfer(1'b1, 8'h00, 32'h101, rd, sl);
    // event in the setup cycle, then in the access cycle
    for (int d = 1; d < 3; d++) begin
      fork
        host_model_i.xfer(1'b0, 8'h04, 32'h0, rd, sl);
        begin
          repeat (d) @(posedge pclk);
          ev <= 19'h00400;
          @(posedge pclk) ev <= 19'h0;
        end
      join
      chk("status", rd, 32'h0);
      #1 chk("irq_n", irq_n, 1'b1);
      @(posedge pclk) #1 chk("irq_n", irq_n, 1'b0);
      host_model_i.service(rd, er);
      chk("status", rd, 32'h8);
    end
  endtask : t_race
  task t_soft;
    @(posedge pclk) ev <= 19'h00001;
    @(posedge pclk) ev <= 19'h0;
    host_model_i.xfer(1'b1, 8'h10, 32'h0, rd, sl);
    #1 chk("irq_n", irq_n, 1'b0);
    host_model_i.xfer(1'b1, 8'h00, 32'h109, rd, sl);
    repeat (2) @(posedge pclk);
    #1 chk("irq_n", irq_n, 1'b1);
    host_model_i.service(rd, er);
    chk("status", rd, 32'h0);
  endtask : t_soft
  task t_ilock;
    run(9'h105, 5'h12, 19'h00800, 1'b0, 4'h4, 8'h40);
    chk("term", n_term, 32'h1);
    host_model_i.xfer(1'b1, 8'h0c, 32'h1, rd, sl);
    run(9'h105, 5'h12, 19'h00800, 1'b1, 4'h0, 8'h0);
    chk("term", n_term, 32'h1);
  endtask : t_ilock

  initial begin
    presetn = 1'b0;
    lv      = 5'h0;
    ev      = 19'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_misc();
    t_table();
    t_race();
    t_soft();
    t_ilock();
    test_done();
  end
endmodule : tb
